// >>> logic/tpo_group.sv
// One 4-bit output group: trigger select, mode and data transfer
`timescale 1ns/1ns
module tpo_group #(
  parameter int GRP_W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Control
  input wire logic [1:0] chan_sel,
  input wire logic nonoverlap,
  input wire logic [GRP_W-1:0] bit_en,
  input wire logic [GRP_W-1:0] next_data,
  // Timer events
  input wire tpo_pkg::tpo_timer_evt_t evt,
  // Port data
  input wire logic sw_wr,
  input wire logic [GRP_W-1:0] sw_data,
  output logic [GRP_W-1:0] port_q
);
  import tpo_pkg::*;

  logic hit_a_r;
  logic hit_b_r;
  logic [GRP_W-1:0] port_r;
  logic [GRP_W-1:0] port_nxt;
  wire logic sel_a = evt.match_a[chan_sel];
  wire logic sel_b = evt.match_b[chan_sel];
  wire logic [GRP_W-1:0] take_a = hit_a_r ? bit_en : '0;
  // Match B only drives zeros, and only in non-overlap mode
  wire logic [GRP_W-1:0] take_b =
    (hit_b_r && nonoverlap) ? (bit_en & ~next_data) : '0;
  wire logic [GRP_W-1:0] take = take_a | take_b;

  assign port_nxt = sw_wr ? sw_data :
    ((port_r & ~take) | (next_data & take));
  assign port_q = port_r;

  // Pulse seen now, transfer one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_a_r <= 1'b0;
      hit_b_r <= 1'b0;
      port_r <= '0;
    end else if (clk_en) begin
      hit_a_r <= sel_a;
      hit_b_r <= sel_b;
      port_r <= port_nxt;
    end
  end
endmodule

// >>> logic/tpo_pkg.sv
// Package: register map, field layout and reset values of the pattern unit
package tpo_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [11:0] TPO_OFS_UPPER_EN = 12'h000;
  localparam logic [11:0] TPO_OFS_TRIG_SEL = 12'h004;
  localparam logic [11:0] TPO_OFS_MODE = 12'h008;
  localparam logic [11:0] TPO_OFS_NEXT_DATA = 12'h00C;
  localparam logic [11:0] TPO_OFS_PORT_DATA = 12'h010;

  // ****************************************
  // Reset values and fixed fields
  // ****************************************
  localparam logic [7:0] TPO_RST_UPPER_EN = 8'h00;
  localparam logic [7:0] TPO_RST_TRIG_SEL = 8'hFF;
  localparam logic [7:0] TPO_RST_MODE = 8'hF0;
  localparam logic [7:0] TPO_RST_NEXT_DATA = 8'h00;
  localparam logic [7:0] TPO_RST_PORT_DATA = 8'h00;
  localparam logic [3:0] TPO_MODE_FIXED_ONES = 4'hF;
  localparam int TPO_MODE_FIXED_LSB = 4;
  localparam int TPO_SEL_W = 2;
  localparam int TPO_GRP_W = 4;

  // ****************************************
  // AXI4-Lite responses
  // ****************************************
  localparam logic [1:0] TPO_RESP_OKAY = 2'h0;
  localparam logic [1:0] TPO_RESP_SLVERR = 2'h2;

  // Compare match events from the timer channels
  typedef struct packed {
    logic [3:0] match_a;
    logic [3:0] match_b;
  } tpo_timer_evt_t;

  // Bus slave states
  typedef enum logic [2:0] {
    TPO_B_IDLE = 3'b001,
    TPO_B_RESP = 3'b010,
    TPO_B_HOLD = 3'b100
  } tpo_bus_state_t;

endpackage

// >>> logic/tpo_top.sv
// Timed pattern output control with AXI4-Lite register slave
`timescale 1ns/1ns

module tpo_top #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer compare match pulses
  input wire tpo_pkg::tpo_timer_evt_t timer_evt,
  // Lower next data and enables from outside this block
  input wire logic [7:0] lower_next_data,
  input wire logic [7:0] lower_bit_enables,
  // Port output data, all four groups
  output logic [15:0] port_output_data
);
  import tpo_pkg::*;

  // ****************************************
  // Parameter check
  // ****************************************
  // Registers are byte wide; any other width has no field layout
  if (DATA_W != 8) begin : g_bad_data_w
    $error("tpo_top supports only DATA_W of 8");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] upper_group_output_enable_r;
  logic [7:0] group_trigger_select_r;
  logic [3:0] group_overlap_mode_r;
  logic [7:0] upper_next_data_r;

  // ****************************************
  // Write channel
  // ****************************************
  logic aw_got_r;
  logic w_got_r;
  logic [11:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // Write address and data may arrive in either order
  wire logic aw_take = s_axi_awvalid && !aw_got_r && !bvalid_r;
  wire logic w_take = s_axi_wvalid && !w_got_r && !bvalid_r;
  wire logic wr_fire = aw_got_r && w_got_r && !bvalid_r;
  wire logic wr_upper_en = wr_fire && wlane_r &&
    (awaddr_r == TPO_OFS_UPPER_EN);
  wire logic wr_trig = wr_fire && wlane_r && (awaddr_r == TPO_OFS_TRIG_SEL);
  wire logic wr_mode = wr_fire && wlane_r && (awaddr_r == TPO_OFS_MODE);
  wire logic wr_next = wr_fire && wlane_r &&
    (awaddr_r == TPO_OFS_NEXT_DATA);
  wire logic wr_port = wr_fire && wlane_r &&
    (awaddr_r == TPO_OFS_PORT_DATA);
  wire logic wr_hit;
  assign wr_hit = (awaddr_r == TPO_OFS_UPPER_EN) ||
    (awaddr_r == TPO_OFS_TRIG_SEL) || (awaddr_r == TPO_OFS_MODE) ||
    (awaddr_r == TPO_OFS_NEXT_DATA) || (awaddr_r == TPO_OFS_PORT_DATA);

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= TPO_RESP_OKAY;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? TPO_RESP_OKAY : TPO_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // No standby input: contents only change on reset or writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_group_output_enable_r <= TPO_RST_UPPER_EN;
      group_trigger_select_r <= TPO_RST_TRIG_SEL;
      group_overlap_mode_r <= TPO_RST_MODE[3:0];
      upper_next_data_r <= TPO_RST_NEXT_DATA;
    end else if (clk_en) begin
      if (wr_upper_en) begin
        upper_group_output_enable_r <= wdata_r;
      end
      if (wr_trig) begin
        group_trigger_select_r <= wdata_r;
      end
      if (wr_mode) begin
        group_overlap_mode_r <= wdata_r[3:0];
      end
      if (wr_next) begin
        upper_next_data_r <= wdata_r;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire logic ar_take = s_axi_arvalid && !rvalid_r;
  wire logic [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
  wire logic [7:0] mode_rd = {TPO_MODE_FIXED_ONES, group_overlap_mode_r};
  logic [7:0] rd_byte;
  logic rd_hit;

  // Address decode for reads
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (rd_addr == TPO_OFS_UPPER_EN) begin
      rd_byte = upper_group_output_enable_r;
    end else if (rd_addr == TPO_OFS_TRIG_SEL) begin
      rd_byte = group_trigger_select_r;
    end else if (rd_addr == TPO_OFS_MODE) begin
      rd_byte = mode_rd;
    end else if (rd_addr == TPO_OFS_NEXT_DATA) begin
      rd_byte = upper_next_data_r;
    end else if (rd_addr == TPO_OFS_PORT_DATA) begin
      rd_byte = port_output_data[15:8];
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= TPO_RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? TPO_RESP_OKAY : TPO_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output groups
  // ****************************************
  // Groups 3 and 2 use the upper registers, 1 and 0 the lower inputs
  wire logic [15:0] all_en = {upper_group_output_enable_r,
    lower_bit_enables};
  wire logic [15:0] all_next = {upper_next_data_r, lower_next_data};

  for (genvar g = 0; g < 4; g++) begin : g_grp
    tpo_group #(
      .GRP_W(TPO_GRP_W)
    ) u_grp (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .chan_sel(group_trigger_select_r[g*TPO_SEL_W +: TPO_SEL_W]),
      .nonoverlap(group_overlap_mode_r[g]),
      .bit_en(all_en[g*TPO_GRP_W +: TPO_GRP_W]),
      .next_data(all_next[g*TPO_GRP_W +: TPO_GRP_W]),
      .evt(timer_evt),
      .sw_wr(wr_port && (g >= 2)),
      .sw_data(g == 3 ? wdata_r[7:4] : wdata_r[3:0]),
      .port_q(port_output_data[g*TPO_GRP_W +: TPO_GRP_W])
    );
  end

endmodule

// >>> verif/tpo_timer_model.sv
// Timer stand-in: match B ends a period, match A follows after a gap
`timescale 1ns/1ns
module tpo_timer_model #(
  parameter int GAP = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Period start per channel
  input wire logic [3:0] go,
  // Match pulses
  output tpo_pkg::tpo_timer_evt_t evt
);
  import tpo_pkg::*;
  int cnt_r [4];
  always @(posedge aclk) begin
    for (int c = 0; c < 4; c++) begin
      evt.match_b[c] <= aresetn && go[c];
      evt.match_a[c] <= aresetn && cnt_r[c] == 1;
      if (!aresetn) cnt_r[c] <= 0;
      else if (go[c]) cnt_r[c] <= GAP;
      else if (cnt_r[c] > 0) cnt_r[c] <= cnt_r[c] - 1;
    end
  end
endmodule

// >>> verif/tpo_top_monitor.sv
// Checker for bus handshakes and port update timing
`timescale 1ns/1ns
module tpo_top_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pattern side
  input wire tpo_pkg::tpo_timer_evt_t timer_evt,
  input wire logic [7:0] lower_bit_enables,
  input wire logic [15:0] port_output_data
);
  import tpo_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !clk_en);
  property p_cause;
    $changed(port_output_data) |-> $past(|timer_evt, 2) || $rose(s_axi_bvalid);
  endproperty
  a_cause: assert property (p_cause)
    else $error("port moved without cause");
  property p_lo_off;
    $past(lower_bit_enables, 2) == 8'h00 && $past(lower_bit_enables) == 8'h00
      |-> $stable(port_output_data[7:0]);
  endproperty
  a_lo_off: assert property (p_lo_off)
    else $error("disabled bits moved");
  property p_port_rst;
    $rose(aresetn) |-> port_output_data == 16'h0000;
  endproperty
  a_port_rst: assert property (p_port_rst)
    else $error("port not cleared by reset");
  property p_wr_ref;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_ref: assert property (p_wr_ref)
    else $error("write taken while response pending");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write response late or early");
  property p_rd_ref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_ref: assert property (p_rd_ref)
    else $error("read taken while data pending");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read data late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped");
  property p_rd_w;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rd_w: assert property (p_rd_w)
    else $error("read data wider than a byte");
endmodule

// >>> verif/tpo_top_test.sv
// Testbench for the pattern output control block
`timescale 1ns/1ns
module tpo_top_test;
  import tpo_pkg::*;
  logic aclk, aresetn, clk_en, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, go, nv;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] lower_next_data, lower_bit_enables, sel;
  logic [15:0] port_output_data, ep, en, nd;
  tpo_timer_evt_t timer_evt;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors, cmp_count;
  tpo_top tpo_top_i (.*);
  tpo_timer_model tpo_timer_model_i (.aclk, .aresetn, .go, .evt(timer_evt));
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // ********
  // Checking
  // ********
  task automatic chk(input logic [33:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk(34'(s_axi_bresp), 34'(bq.pop_front()));
    end
  end
  task automatic print_verdict();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ********
  // Bus tasks
  // ********
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, b;
    bq.push_back(a > TPO_OFS_PORT_DATA ? TPO_RESP_SLVERR : TPO_RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b = 0;
    for (int k = 0; k < 50 && !b; k++) begin
      #1 aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d);
    logic ar, r;
    rq.push_back({a > TPO_OFS_PORT_DATA ? TPO_RESP_SLVERR : TPO_RESP_OKAY,
                  24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    r = 0;
    for (int k = 0; k < 50 && !r; k++) begin
      #1 ar = s_axi_arready;
      r = s_axi_rvalid;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
  endtask
  function automatic void upd(input logic [1:0] c, input logic a);
    logic [15:0] m;
    for (int g = 0; g < 4; g++) begin
      m = en & (16'hF << (4 * g));
      if (sel[2*g +: 2] == c && a) ep = (ep & ~m) | (nd & m);
      else if (sel[2*g +: 2] == c && nv[g]) ep = ep & ~(m & ~nd);
    end
  endfunction
  // Match B first, then match A after the gap
  task automatic fire(input logic [1:0] c);
    @(posedge aclk);
    go <= 4'h1 << c;
    @(posedge aclk);
    go <= 4'h0;
    repeat (3) @(posedge aclk);
    upd(c, 1'b0);
    rd(TPO_OFS_PORT_DATA, ep[15:8]);
    chk(34'(port_output_data[7:0]), 34'(ep[7:0]));
    for (int k = 0; k < 40 && !timer_evt.match_a[c]; k++) @(posedge aclk);
    repeat (3) @(posedge aclk);
    upd(c, 1'b1);
    rd(TPO_OFS_PORT_DATA, ep[15:8]);
    chk(34'(port_output_data[7:0]), 34'(ep[7:0]));
  endtask
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
    // Responses are always accepted at once
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    {s_axi_wdata, lower_next_data, lower_bit_enables, go, ep} = '0;
    clk_en = 1'b1;
    s_axi_wstrb = 4'h1;
    void'($urandom(67406));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TPO_OFS_UPPER_EN, 8'h00);
    rd(TPO_OFS_TRIG_SEL, 8'hFF);
    rd(TPO_OFS_MODE, 8'hF0);
    rd(12'h014, 8'h00);
    wr(12'h014, 8'h5A);
    s_axi_wstrb <= 4'h0;
    wr(TPO_OFS_UPPER_EN, 8'hA5);
    s_axi_wstrb <= 4'h1;
    rd(TPO_OFS_UPPER_EN, 8'h00);
    $display("test reset values done");
    for (int it = 0; it < 4; it++) begin
      nd = 16'($urandom);
      nd[7:0] = ~ep[7:0];
      en = 16'($urandom);
      nv = (it == 0) ? 4'h0 : (it == 1) ? 4'hF : 4'($urandom);
      sel = {it[1:0], it[1:0] ^ 2'h1, it[1:0] ^ 2'h2, it[1:0] ^ 2'h3};
      wr(TPO_OFS_TRIG_SEL, sel);
      rd(TPO_OFS_TRIG_SEL, sel);
      wr(TPO_OFS_UPPER_EN, en[15:8]);
      rd(TPO_OFS_UPPER_EN, en[15:8]);
      wr(TPO_OFS_MODE, {4'hF, nv});
      rd(TPO_OFS_MODE, {4'hF, nv});
      wr(TPO_OFS_NEXT_DATA, nd[15:8]);
      wr(TPO_OFS_PORT_DATA, ~nd[15:8]);
      ep[15:8] = ~nd[15:8];
      lower_next_data <= nd[7:0];
      lower_bit_enables <= en[7:0];
      for (int c = 0; c < 4; c++) fire(2'(c));
      $display("test channel pass %0d done", it);
    end
    print_verdict();
  end
endmodule
bind tpo_top tpo_top_monitor tpo_top_monitor_i (.*);
